// *** inc/timer16_pkg.sv ***
// timer16_pkg: register offsets, field positions, modes and codes for
// the 16-bit timer with input capture.
// assumes an 8-bit cpu i/o port and a 4-bit register address.
package timer16_pkg;

   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int ADDR_W = 4;                 // register address width
   localparam int DATA_W = 8;                 // cpu data bus width
   localparam int CNT_W = 16;                 // counter width

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [3:0] OFS_CTRL_A = 4'h0;  // timer_control_a
   localparam logic [3:0] OFS_CTRL_B = 4'h1;  // timer_control_b
   localparam logic [3:0] OFS_CNT_LO = 4'h2;  // counter_low_byte
   localparam logic [3:0] OFS_CNT_HI = 4'h3;  // counter_high_byte
   localparam logic [3:0] OFS_CAP_LO = 4'h4;  // capture_low_byte
   localparam logic [3:0] OFS_CAP_HI = 4'h5;  // capture_high_byte
   localparam logic [3:0] OFS_FLAGS = 4'h6;   // interrupt flags
   localparam logic [3:0] OFS_MASK = 4'h7;    // interrupt enables
   localparam logic [3:0] OFS_CMP_CTRL = 4'h8; // comparator_control_status

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int A_WGM_LO = 0;               // waveform bits 1:0 in control a
   localparam int B_CS_LO = 0;                // tick_source_select 2:0
   localparam int B_WGM_HI = 3;               // waveform bits 3:2 in control b
   localparam int B_EDGE = 6;                 // capture edge, 1 = rising
   localparam int B_NOISE = 7;                // noise_filter_enable
   localparam int F_OVF = 0;                  // overflow_flag
   localparam int F_CAP = 1;                  // capture_flag
   localparam int CMP_SEL = 2;                // comparator_capture_select

   // ----------------------------------------
   // reset values and fixed tops
   // ----------------------------------------
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [15:0] TOP_8BIT = 16'h00ff;
   localparam logic [15:0] TOP_9BIT = 16'h01ff;
   localparam logic [15:0] TOP_10BIT = 16'h03ff;

   // ----------------------------------------
   // tick source codes
   // ----------------------------------------
   localparam logic [2:0] CS_STOP = 3'h0;     // no ticks
   localparam logic [2:0] CS_DIV1 = 3'h1;     // every system clock
   localparam logic [2:0] CS_EXT_FALL = 3'h6; // external pin, falling
   localparam logic [2:0] CS_EXT_RISE = 3'h7; // external pin, rising
   localparam int PRESC_N = 4;                // prescaled taps, codes 2..5

   // ----------------------------------------
   // noise filter
   // ----------------------------------------
   localparam int FILT_SAMPLES = 4;           // equal samples to change level

endpackage

// *** verilog/sync_edge_filter.sv ***
// sync_edge_filter: two-stage synchroniser, optional four-sample noise
// filter and edge detector for one asynchronous input.
// assumes sys_clk is the only clock; output pulse lasts one cycle.
`timescale 1ns/1ps

module sync_edge_filter
   import timer16_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // control
   input wire logic raw_in,
   input wire logic filter_en,
   input wire logic edge_rise,
   // result
   output logic edge_pulse
);

   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic sync1_reg;                           // first stage, read by sync2 only
   logic sync2_reg;                           // synchronised level
   logic [FILT_SAMPLES-1:0] hist_reg;         // filter sample history
   logic level_reg;                           // level seen by edge detector
   logic prev_reg;                            // previous level
   logic agree;                               // all samples equal

   // two flip-flop synchroniser
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
      end
   end

   // sample history for the filter
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hist_reg <= '0;
      end else begin
         hist_reg <= {hist_reg[FILT_SAMPLES-2:0], sync2_reg};
      end
   end

   // samples agree when all ones or all zeros
   assign agree = (&hist_reg) | ~(|hist_reg);

   // filtered or direct level
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         level_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= level_reg;
         if (!filter_en) begin
            level_reg <= sync2_reg;
         end else if (agree) begin
            level_reg <= hist_reg[0];
         end
      end
   end

   // edge detector, polarity selectable
   assign edge_pulse = edge_rise ? (level_reg & ~prev_reg) : (~level_reg & prev_reg);

endmodule // sync_edge_filter

// *** verilog/timer16_capture.sv ***
// timer16_capture: 16-bit up/down timer/counter with input capture,
// reached by the cpu through an 8-bit i/o port and a shared high byte.
// assumes prescaler taps come as one-cycle enables on sys_clk.
`timescale 1ns/1ps

module timer16_capture
   import timer16_pkg::*;
#(
   parameter bit HAS_COMPARATOR = 1'b1        // timer 1 has comparator trigger
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // cpu i/o port
   input wire logic [ADDR_W-1:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [DATA_W-1:0] io_wdata,
   output logic [DATA_W-1:0] io_rdata,
   // prescaler taps, codes 2 to 5
   input wire logic [PRESC_N-1:0] presc_tick,
   // external pins and comparator
   input wire logic external_tick_pin,
   input wire logic capture_pin,
   input wire logic comparator_output,
   // interrupt requests and service acknowledges
   output logic overflow_irq,
   output logic capture_irq,
   input wire logic overflow_irq_ack,
   input wire logic capture_irq_ack
);

   // ----------------------------------------
   // mode helpers
   // ----------------------------------------

   // capture register defines top
   function automatic logic icr_is_top(input logic [3:0] m);
      icr_is_top = (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
   endfunction

   // dual-slope (phase correct) modes
   function automatic logic is_dual(input logic [3:0] m);
      is_dual = (m != 4'h0) && (m <= 4'hb) && !((m >= 4'h4) && (m <= 4'h7));
   endfunction

   // clear on top match, overflow only at max
   function automatic logic is_ctc(input logic [3:0] m);
      is_ctc = (m == 4'h4) || (m == 4'hc);
   endfunction

   // top value of the count sequence
   function automatic logic [CNT_W-1:0] top_of(input logic [3:0] m,
                                                input logic [CNT_W-1:0] icr);
      case (m[1:0])
         2'h1: top_of = TOP_8BIT;
         2'h2: top_of = TOP_9BIT;
         2'h3: top_of = TOP_10BIT;
         default: top_of = CNT_MAX;
      endcase
      if (icr_is_top(m)) begin
         top_of = icr;
      end else if (m[3] || m == 4'h4) begin
         top_of = CNT_MAX;                      // compare-unit tops not present
      end
   endfunction

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] ctrl_a_reg;                    // timer_control_a
   logic [7:0] ctrl_b_reg;                    // timer_control_b
   logic [7:0] temp_reg;                      // shared high byte
   logic [CNT_W-1:0] count_value_reg;         // counter
   logic count_down_reg;                      // dual-slope direction
   logic [CNT_W-1:0] capture_reg;             // capture_register
   logic overflow_flag_reg;                   // overflow_flag
   logic capture_flag_reg;                    // capture_flag
   logic overflow_irq_enable_reg;             // overflow interrupt enable
   logic capture_irq_enable_reg;              // capture_irq_enable
   logic comparator_capture_select_reg;       // trigger from comparator
   logic [DATA_W-1:0] rdata_reg;              // read data

   // ----------------------------------------
   // decoded controls
   // ----------------------------------------
   logic [3:0] waveform_mode_field;
   logic [2:0] tick_source_select;
   logic [CNT_W-1:0] top_value;
   logic timer_tick;
   logic ext_edge;
   logic cap_edge;
   logic cap_src;
   logic capture_event;
   logic wr_cnt_lo;
   logic wr_cap_lo;
   logic wr_flags;
   logic rd_cnt_lo;
   logic rd_cap_lo;
   logic at_top;
   logic ovf_event;

   assign waveform_mode_field = {ctrl_b_reg[B_WGM_HI+1:B_WGM_HI],
                                 ctrl_a_reg[A_WGM_LO+1:A_WGM_LO]};
   assign tick_source_select = ctrl_b_reg[B_CS_LO+2:B_CS_LO];
   assign top_value = top_of(waveform_mode_field, capture_reg);
   assign at_top = (count_value_reg >= top_value);

   // access strobes
   assign wr_cnt_lo = io_wr && (io_addr == OFS_CNT_LO);
   assign wr_cap_lo = io_wr && (io_addr == OFS_CAP_LO);
   assign wr_flags = io_wr && (io_addr == OFS_FLAGS);
   assign rd_cnt_lo = io_rd && (io_addr == OFS_CNT_LO);
   assign rd_cap_lo = io_rd && (io_addr == OFS_CAP_LO);

   // ----------------------------------------
   // tick source selection
   // ----------------------------------------

   // external tick pin: synchronised and edge detected, no filter
   sync_edge_filter u_ext_tick (
      .sys_clk(sys_clk),
      .rst(rst),
      .raw_in(external_tick_pin),
      .filter_en(1'b0),
      .edge_rise(tick_source_select == CS_EXT_RISE),
      .edge_pulse(ext_edge)
   );

   // tick select, code zero gives no ticks
   always_comb begin
      unique case (tick_source_select)
         CS_STOP: timer_tick = 1'b0;
         CS_DIV1: timer_tick = 1'b1;
         CS_EXT_FALL,
         CS_EXT_RISE: timer_tick = ext_edge;
         default: timer_tick = presc_tick[2'(tick_source_select - 3'h2)];
      endcase
   end

   // ----------------------------------------
   // capture source and edge detector
   // ----------------------------------------

   // the pin is read at the pad, so port-driven levels capture too
   assign cap_src = (HAS_COMPARATOR && comparator_capture_select_reg) ?
                    comparator_output : capture_pin;

   // same synchroniser and detector as the tick pin, plus filter
   sync_edge_filter u_cap_edge (
      .sys_clk(sys_clk),
      .rst(rst),
      .raw_in(cap_src),
      .filter_en(ctrl_b_reg[B_NOISE]),
      .edge_rise(ctrl_b_reg[B_EDGE]),
      .edge_pulse(cap_edge)
   );

   // no captures while capture register holds top
   assign capture_event = cap_edge && !icr_is_top(waveform_mode_field);

   // ----------------------------------------
   // control registers
   // ----------------------------------------

   // controls a and b, comparator select, interrupt enables
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_a_reg <= BYTE_ZERO;
         ctrl_b_reg <= BYTE_ZERO;
         comparator_capture_select_reg <= 1'b0;
         overflow_irq_enable_reg <= 1'b0;
         capture_irq_enable_reg <= 1'b0;
      end else if (io_wr) begin
         unique case (io_addr)
            OFS_CTRL_A: ctrl_a_reg <= io_wdata;
            OFS_CTRL_B: ctrl_b_reg <= io_wdata;
            OFS_CMP_CTRL: comparator_capture_select_reg <= io_wdata[CMP_SEL] & HAS_COMPARATOR;
            OFS_MASK: begin
               overflow_irq_enable_reg <= io_wdata[F_OVF];
               capture_irq_enable_reg <= io_wdata[F_CAP];
            end
            default: ;                           // other locations elsewhere
         endcase
      end
   end

   // ----------------------------------------
   // shared temporary high byte
   // ----------------------------------------

   // written by any high location, reloaded by low reads, otherwise kept
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         temp_reg <= BYTE_ZERO;
      end else if (rd_cnt_lo) begin
         temp_reg <= count_value_reg[CNT_W-1:DATA_W];
      end else if (rd_cap_lo) begin
         temp_reg <= capture_reg[CNT_W-1:DATA_W];
      end else if (io_wr && (io_addr == OFS_CNT_HI || io_addr == OFS_CAP_HI)) begin
         temp_reg <= io_wdata;
      end
   end

   // ----------------------------------------
   // counter unit
   // ----------------------------------------

   // cpu write first, then tick-driven count, clear or turn
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         count_value_reg <= CNT_ZERO;
         count_down_reg <= 1'b0;
      end else if (wr_cnt_lo) begin
         count_value_reg <= {temp_reg, io_wdata};
      end else if (timer_tick) begin
         if (is_dual(waveform_mode_field)) begin
            if (!count_down_reg && at_top) begin
               count_down_reg <= 1'b1;
               count_value_reg <= count_value_reg - CNT_ONE;
            end else if (count_down_reg && count_value_reg == CNT_ZERO) begin
               count_down_reg <= 1'b0;
               count_value_reg <= CNT_ONE;
            end else if (count_down_reg) begin
               count_value_reg <= count_value_reg - CNT_ONE;
            end else begin
               count_value_reg <= count_value_reg + CNT_ONE;
            end
         end else begin
            count_down_reg <= 1'b0;
            if (at_top) begin
               count_value_reg <= CNT_ZERO;
            end else begin
               count_value_reg <= count_value_reg + CNT_ONE;
            end
         end
      end
   end

   // overflow point: bottom turn, max in clear-on-top, else top wrap
   always_comb begin
      if (!timer_tick || wr_cnt_lo) begin
         ovf_event = 1'b0;
      end else if (is_dual(waveform_mode_field)) begin
         ovf_event = count_down_reg && (count_value_reg == CNT_ZERO);
      end else if (is_ctc(waveform_mode_field)) begin
         ovf_event = (count_value_reg == CNT_MAX);
      end else begin
         ovf_event = at_top;
      end
   end

   // ----------------------------------------
   // capture register
   // ----------------------------------------

   // time stamp on capture, cpu load only in top modes
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         capture_reg <= CNT_ZERO;
      end else if (capture_event) begin
         capture_reg <= count_value_reg;
      end else if (wr_cap_lo && icr_is_top(waveform_mode_field)) begin
         capture_reg <= {temp_reg, io_wdata};
      end
   end

   // ----------------------------------------
   // flags: a set in the clearing cycle wins
   // ----------------------------------------

   // overflow flag
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         overflow_flag_reg <= 1'b0;
      end else if (ovf_event) begin
         overflow_flag_reg <= 1'b1;
      end else if ((wr_flags && io_wdata[F_OVF]) || overflow_irq_ack) begin
         overflow_flag_reg <= 1'b0;
      end
   end

   // capture flag, same cycle as the time stamp
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         capture_flag_reg <= 1'b0;
      end else if (capture_event) begin
         capture_flag_reg <= 1'b1;
      end else if (wr_flags && io_wdata[F_CAP]) begin
         capture_flag_reg <= 1'b0;
      end else if (capture_irq_ack) begin
         capture_flag_reg <= 1'b0;
      end
   end

   // interrupt requests
   assign overflow_irq = overflow_flag_reg & overflow_irq_enable_reg;
   assign capture_irq = capture_flag_reg & capture_irq_enable_reg;

   // ----------------------------------------
   // read data, one cycle after the strobe
   // ----------------------------------------

   // high locations return the temporary byte
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= BYTE_ZERO;
      end else if (io_rd) begin
         unique case (io_addr)
            OFS_CTRL_A: rdata_reg <= ctrl_a_reg;
            OFS_CTRL_B: rdata_reg <= ctrl_b_reg;
            OFS_CNT_LO: rdata_reg <= count_value_reg[DATA_W-1:0];
            OFS_CNT_HI: rdata_reg <= temp_reg;
            OFS_CAP_LO: rdata_reg <= capture_reg[DATA_W-1:0];
            OFS_CAP_HI: rdata_reg <= temp_reg;
            OFS_FLAGS: rdata_reg <= 8'(({capture_flag_reg, overflow_flag_reg}) << F_OVF);
            OFS_MASK: rdata_reg <= 8'(({capture_irq_enable_reg,
                                         overflow_irq_enable_reg}) << F_OVF);
            OFS_CMP_CTRL: rdata_reg <= 8'(comparator_capture_select_reg) << CMP_SEL;
            default: rdata_reg <= BYTE_ZERO;      // unmapped reads zero
         endcase
      end
   end

   assign io_rdata = rdata_reg;

endmodule // timer16_capture

// *** tb/timer16_capture_assertions.sv ***
// checker: port timing properties of the 16-bit timer with capture.
// assumes one clock domain and an active high asynchronous rst.
`timescale 1ns/1ps
module timer16_capture_checker
   import timer16_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // cpu port
   input wire logic [ADDR_W-1:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [DATA_W-1:0] io_wdata,
   input wire logic [DATA_W-1:0] io_rdata,
   // interrupts
   input wire logic overflow_irq,
   input wire logic capture_irq,
   input wire logic overflow_irq_ack,
   input wire logic capture_irq_ack
);
   logic [2:0] cs_reg; // shadow of tick select
   // shadow tick select, so counter readback is only checked while stopped
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cs_reg <= CS_STOP;
      end else if (io_wr && io_addr == OFS_CTRL_B) begin
         cs_reg <= io_wdata[B_CS_LO+2:B_CS_LO];
      end
   end
   // ---------------------------
   // properties
   // ---------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_wr(a); io_wr && io_addr == a; endsequence
   sequence s_rd(a); io_rd && io_addr == a; endsequence
   a_cnt_load: assert property (
      s_wr(OFS_CNT_LO) ##2 s_rd(OFS_CNT_LO) ##0 cs_reg == CS_STOP
      |=> io_rdata == $past(io_wdata, 3)) else $error("counter low byte lost");
   a_temp_keep: assert property (
      s_wr(OFS_CNT_HI) ##2 s_rd(OFS_CNT_HI)
      |=> io_rdata == $past(io_wdata, 3)) else $error("staged high byte lost");
   a_rd_hold: assert property (
      !io_rd |=> $stable(io_rdata)) else $error("read data moved without a read");
   a_cap_clear: assert property (
      s_wr(OFS_FLAGS) ##0 io_wdata[F_CAP] |=> !capture_irq) else $error("capture flag kept");
   a_ovf_clear: assert property (
      s_wr(OFS_FLAGS) ##0 io_wdata[F_OVF] |=> !overflow_irq) else $error("overflow flag kept");
   a_cap_ack: assert property (
      capture_irq_ack |=> !capture_irq) else $error("capture irq survived service");
   a_ovf_ack: assert property (
      overflow_irq_ack |=> !overflow_irq) else $error("overflow irq survived service");
   a_irq_stand: assert property (
      capture_irq && !capture_irq_ack && !(io_wr && io_addr == OFS_FLAGS)
      && !(io_wr && io_addr == OFS_MASK)
      |=> capture_irq) else $error("capture irq dropped by itself");
endmodule // timer16_capture_checker

bind timer16_capture timer16_capture_checker u_checker (
   .sys_clk(sys_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
   .io_wdata(io_wdata), .io_rdata(io_rdata), .overflow_irq(overflow_irq),
   .capture_irq(capture_irq), .overflow_irq_ack(overflow_irq_ack),
   .capture_irq_ack(capture_irq_ack));

// *** tb/cpu_bus_model.sv ***
// cpu_bus_model: cpu side of the timer i/o port, byte and 16-bit access.
// assumes a strobe is taken at the rising edge after it is raised.
`timescale 1ns/1ps
module cpu_bus_model
   import timer16_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // cpu port
   output logic [ADDR_W-1:0] io_addr = 4'hf,
   output logic io_wr = 1'b0,
   output logic io_rd = 1'b0,
   output logic [DATA_W-1:0] io_wdata = 8'h00,
   input wire logic [DATA_W-1:0] io_rdata
);
   // one strobe cycle; released address and data are turned over
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= w;
      io_rd <= !w;
      @(posedge sys_clk);
      io_wr <= 1'b0;
      io_rd <= 1'b0;
      io_addr <= ~a;
      io_wdata <= ~d;
   endtask
   // byte read, data taken once settled after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      acc(1'b0, a, 8'h00);
      @(negedge sys_clk);
      d = io_rdata;
   endtask
   // 16-bit write, high byte staged first
   task automatic w16(input logic [3:0] lo, input logic [15:0] v);
      acc(1'b1, lo + 4'h1, v[15:8]);
      acc(1'b1, lo, v[7:0]);
   endtask
   // 16-bit read, low byte first to latch the high byte
   task automatic r16(input logic [3:0] lo, output logic [15:0] v);
      rd(lo, v[7:0]);
      rd(lo + 4'h1, v[15:8]);
   endtask
endmodule // cpu_bus_model

// *** tb/timer16_capture_test.sv ***
// timer16_capture_test: directed tests of counter, capture and flags.
// assumes cpu_bus_model for bus cycles and the bound checker.
`timescale 1ns/1ps
module timer16_capture_test
   import timer16_pkg::*;
   ;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] io_addr;
   logic io_wr, io_rd, overflow_irq, capture_irq;
   logic [DATA_W-1:0] io_wdata, io_rdata;
   logic [PRESC_N-1:0] presc_tick = 4'h0;
   logic external_tick_pin = 1'b0;
   logic capture_pin = 1'b0;
   logic comparator_output = 1'b0;
   logic overflow_irq_ack = 1'b0;
   logic capture_irq_ack = 1'b0;
   int miscompares = 0;
   int check_count = 0;
   always #50 sys_clk = ~sys_clk;
   timer16_capture #(.HAS_COMPARATOR(1'b1)) u_timer16_capture (
      .sys_clk(sys_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .presc_tick(presc_tick),
      .external_tick_pin(external_tick_pin), .capture_pin(capture_pin),
      .comparator_output(comparator_output), .overflow_irq(overflow_irq),
      .capture_irq(capture_irq), .overflow_irq_ack(overflow_irq_ack),
      .capture_irq_ack(capture_irq_ack));
   cpu_bus_model u_cpu_bus_model (
      .sys_clk(sys_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata));
   // ---------------------------
   // helpers
   // ---------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      u_cpu_bus_model.acc(1'b1, a, d);
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_cpu_bus_model.rd(a, d);
      chk({8'h00, d}, {8'h00, e});
   endtask
   task automatic r16c(input logic [3:0] lo, input logic [15:0] e);
      logic [15:0] d;
      u_cpu_bus_model.r16(lo, d);
      chk(d, e);
   endtask
   // single-cycle ticks on the first prescaler tap
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge sys_clk) presc_tick <= 4'h1;
         @(posedge sys_clk) presc_tick <= 4'h0;
      end
   endtask
   task automatic end_sim;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // watchdog, well beyond the few hundred cycles the tests need
   initial begin
      #1000000;
      miscompares++;
      end_sim();
   end
   // ---------------------------
   // test sequence
   // ---------------------------
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      r16c(OFS_CNT_LO, 16'h0000);
      rc(4'hf, 8'h00);
      u_cpu_bus_model.w16(OFS_CNT_LO, 16'h1234);
      r16c(OFS_CNT_LO, 16'h1234);
      // each tick source from code 2 to 7 counts once, pulses on unselected taps are ignored
      u_cpu_bus_model.w16(OFS_CNT_LO, 16'h0000);
      @(posedge sys_clk) external_tick_pin <= 1'b1;
      for (int k = 2; k < 8; k++) begin
         wr(OFS_CTRL_B, 8'(k));
         @(posedge sys_clk) presc_tick <= (k < 6) ? ~(4'h1 << (k - 2)) : 4'hf;
         @(posedge sys_clk) presc_tick <= (k < 6) ? (4'h1 << (k - 2)) : 4'h0;
         if (k > 5) external_tick_pin <= ~external_tick_pin;
         @(posedge sys_clk) presc_tick <= 4'h0;
         repeat (6) @(posedge sys_clk);
         r16c(OFS_CNT_LO, 16'(k - 1));
      end
      // wrap through the top sets overflow, service clears it
      wr(OFS_CTRL_B, 8'h02);
      u_cpu_bus_model.w16(OFS_CNT_LO, 16'hfffe);
      tick(2);
      r16c(OFS_CNT_LO, 16'h0000);
      rc(OFS_FLAGS, 8'h01);
      wr(OFS_MASK, 8'h01);
      @(negedge sys_clk) chk(16'(overflow_irq), 16'h0001);
      @(posedge sys_clk) overflow_irq_ack <= 1'b1;
      @(posedge sys_clk) overflow_irq_ack <= 1'b0;
      @(negedge sys_clk) chk(16'(overflow_irq), 16'h0000);
      // write-one clears a standing overflow flag
      u_cpu_bus_model.w16(OFS_CNT_LO, 16'hffff);
      tick(1);
      @(negedge sys_clk) chk(16'(overflow_irq), 16'h0001);
      wr(OFS_FLAGS, 8'h01);
      rc(OFS_FLAGS, 8'h00);
      // low byte write and tick in the same cycle
      wr(OFS_CNT_HI, 8'h20);
      fork
         wr(OFS_CNT_LO, 8'h40);
         begin
            @(posedge sys_clk) presc_tick <= 4'h1;
            @(posedge sys_clk) presc_tick <= 4'h0;
         end
      join
      r16c(OFS_CNT_LO, 16'h2040);
      // dual slope turns down at the fixed 8-bit top
      wr(OFS_CTRL_A, 8'h01);
      u_cpu_bus_model.w16(OFS_CNT_LO, 16'h00fe);
      tick(3);
      r16c(OFS_CNT_LO, 16'h00fd);
      wr(OFS_CTRL_A, 8'h00);
      // rising capture of a stopped counter
      wr(OFS_CTRL_B, 8'h40);
      u_cpu_bus_model.w16(OFS_CNT_LO, 16'h4321);
      @(posedge sys_clk) capture_pin <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rc(OFS_FLAGS, 8'h02);
      r16c(OFS_CAP_LO, 16'h4321);
      wr(OFS_FLAGS, 8'h03);
      rc(OFS_FLAGS, 8'h00);
      // falling capture raises the irq until serviced
      wr(OFS_CTRL_B, 8'h00);
      wr(OFS_MASK, 8'h02);
      u_cpu_bus_model.w16(OFS_CNT_LO, 16'h1234);
      @(posedge sys_clk) capture_pin <= 1'b0;
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk) chk(16'(capture_irq), 16'h0001);
      r16c(OFS_CAP_LO, 16'h1234);
      @(posedge sys_clk) capture_irq_ack <= 1'b1;
      @(posedge sys_clk) capture_irq_ack <= 1'b0;
      @(negedge sys_clk) chk(16'(capture_irq), 16'h0000);
      // filter drops a three-cycle pulse, passes a held level
      wr(OFS_CTRL_B, 8'hc0);
      @(posedge sys_clk) capture_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      capture_pin <= 1'b0;
      repeat (12) @(posedge sys_clk);
      rc(OFS_FLAGS, 8'h00);
      @(posedge sys_clk) capture_pin <= 1'b1;
      repeat (12) @(posedge sys_clk);
      rc(OFS_FLAGS, 8'h02);
      // comparator trigger; switching may capture, so clear after it
      wr(OFS_CMP_CTRL, 8'h04);
      repeat (12) @(posedge sys_clk);
      wr(OFS_FLAGS, 8'h02);
      @(posedge sys_clk) comparator_output <= 1'b1;
      repeat (12) @(posedge sys_clk);
      rc(OFS_FLAGS, 8'h02);
      wr(OFS_FLAGS, 8'h02);
      // capture register refuses writes outside capture-as-top modes
      u_cpu_bus_model.w16(OFS_CAP_LO, 16'h5566);
      r16c(OFS_CAP_LO, 16'h1234);
      // mode 14: staged high byte reused, captures disabled
      wr(OFS_CTRL_A, 8'h02);
      wr(OFS_CTRL_B, 8'h98);
      wr(OFS_CNT_HI, 8'h01);
      rc(OFS_CNT_HI, 8'h01);
      wr(OFS_CNT_LO, 8'hff);
      wr(OFS_CAP_LO, 8'h80);
      @(posedge sys_clk) comparator_output <= 1'b0;
      repeat (12) @(posedge sys_clk);
      rc(OFS_FLAGS, 8'h00);
      r16c(OFS_CAP_LO, 16'h0180);
      r16c(OFS_CNT_LO, 16'h01ff);
      end_sim();
   end
endmodule // timer16_capture_test
